// *** hdl/vic_cfg.svh ***
// Purpose: Constants of the vectored interrupt controller.
// Assumes: Included by its bare name; definitions only.
// Notes:   Offsets are byte addresses within a 4 KB window.
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH
// ----------------------------------------
// Sizes, bit positions and fixed values
// ----------------------------------------
`define VIC_NUM_SRC     19
`define VIC_NUM_SLOT    16
`define VIC_SRC_W       5
`define VIC_SLOT_W      4
`define VIC_EV_W        2
`define VIC_EV_FAST     0
`define VIC_EV_IRQ      1
`define VIC_CTRL_EN     5
`define VIC_HSIZE_WORD  3'h2
`define VIC_ZERO32      32'h0000_0000
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define VIC_OFF_FAST_STAT 12'h000
`define VIC_OFF_IRQ_STAT 12'h004
`define VIC_OFF_RAW      12'h008
`define VIC_OFF_ENABLE   12'h00C
`define VIC_OFF_SELECT   12'h010
`define VIC_OFF_VECT     12'h014
`define VIC_OFF_DEFAULT  12'h018
`define VIC_OFF_INT_STAT 12'h01C
`define VIC_OFF_INT_MASK 12'h020
`define VIC_PAGE_VADDR   4'h1
`define VIC_PAGE_VCTRL   4'h2
`endif

// *** hdl/vic_pkg.sv ***
// Purpose: Types of the vectored interrupt controller.
// Assumes: Sizes come from vic_cfg.svh.
// Notes:   Nothing here is imported; users write vic_pkg::name.
`include "vic_cfg.svh"
package vic_pkg;
    typedef logic [`VIC_NUM_SRC-1:0]  vic_src_vec_t;
    typedef logic [`VIC_SRC_W-1:0]    vic_src_idx_t;
    typedef logic [`VIC_SLOT_W-1:0]   vic_slot_idx_t;
    typedef logic [31:0]              vic_word_t;
endpackage

// *** hdl/vic_top.sv ***
// Purpose: Vectored interrupt controller with an AHB-Lite register slave.
// Assumes: Request lines come from logic on clk_i; single-word accesses only.
// Notes:   Zero wait states; a read returns the value sampled in its address phase.
// Functional notes
// RL1: Every request is sorted by software into fast, vectored or non-vectored class.
// RL2: Class and slot settings may change any time and take effect next cycle.
// RL3: Fast-class requests outrank every vectored and non-vectored request.
// RL4: All fast-class requests merge into one fast interrupt output.
// RL5: A readable word shows which fast-class sources are requesting.
// RL6: Sixteen vectored slots; any source may sit in any slot.
// RL7: Slot 0 ranks highest, slot 15 lowest.
// RL8: Normal requests not in a slot are non-vectored, lowest priority.
// RL9: All vectored and non-vectored requests merge into one normal output.
// RL10: Vector register returns the routine address of the best active slot.
// RL11: With no active slot the vector register returns the default address.
// RL12: A readable word shows which normal-class requests are active.
// RL13: One request line per peripheral, channels 0 to 18.
// RL14: Requests sampled on clk_i; outputs synchronous; settings clear on reset.
`timescale 1ns/10ps
`include "vic_cfg.svh"
module vic_top
(
    // Clock and reset.
    input  wire logic                 clk_i,
    input  wire logic                 arst_n_i,
    // AHB-Lite slave.
    input  wire logic                 hsel_i,
    input  wire logic [31:0]          haddr_i,
    input  wire logic [1:0]           htrans_i,
    input  wire logic                 hwrite_i,
    input  wire logic [2:0]           hsize_i,
    input  wire logic [31:0]          hwdata_i,
    input  wire logic                 hready_i,
    output logic      [31:0]          hrdata_o,
    output logic                      hreadyout_o,
    output logic                      hresp_o,
    // Peripheral request lines.
    input  wire vic_pkg::vic_src_vec_t irq_req_i,
    // Requests to the core and the summary interrupt.
    output logic                      fast_interrupt_request_o,
    output logic                      irq_o,
    output logic                      int_o
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    vic_pkg::vic_src_vec_t req_reg;
    vic_pkg::vic_src_vec_t enable_reg;
    vic_pkg::vic_src_vec_t select_reg;
    vic_pkg::vic_word_t    default_reg;
    vic_pkg::vic_word_t    vect_reg;
    vic_pkg::vic_word_t    slot_addr_reg [`VIC_NUM_SLOT];
    vic_pkg::vic_src_idx_t slot_src_reg  [`VIC_NUM_SLOT];
    logic [`VIC_NUM_SLOT-1:0] slot_en_reg;
    logic [`VIC_EV_W-1:0]  int_stat_reg;
    logic [`VIC_EV_W-1:0]  int_stat_next;
    logic [`VIC_EV_W-1:0]  int_mask_reg;
    logic                  fast_reg;
    logic                  irq_reg;
    logic                  int_reg;
    logic                  wr_pend_reg;
    logic [11:0]           wr_addr_reg;
    vic_pkg::vic_word_t    rdata_reg;

    vic_pkg::vic_src_vec_t fast_stat;
    vic_pkg::vic_src_vec_t irq_stat;
    logic [`VIC_NUM_SLOT-1:0] slot_hit;
    vic_pkg::vic_slot_idx_t win_idx;
    logic                  hit_any;
    logic [`VIC_EV_W-1:0]  events;
    logic                  addr_ok;
    logic                  rd_take;
    logic [11:0]           a_off;
    vic_pkg::vic_word_t    rd_mux;

    // ----------------------------------------
    // Request sampling and classification
    // ----------------------------------------

    // Lines come from peripherals on this clock, so one register suffices.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            req_reg <= '0;
        else
            req_reg <= irq_req_i; // RL14 RL13
    end

    // The select bit decides fast versus normal; the two words never overlap.
    assign fast_stat = req_reg & enable_reg & select_reg; // RL1 RL5
    assign irq_stat = req_reg & enable_reg & ~select_reg; // RL1 RL12

    // A slot only sees normal-class requests, so fast sources never vector.
    always_comb
    begin
        for (int n = 0; n < `VIC_NUM_SLOT; n++)
        begin
            slot_hit[n] = 1'b0;
            if (slot_en_reg[n] && (32'(slot_src_reg[n]) < `VIC_NUM_SRC))
                slot_hit[n] = irq_stat[slot_src_reg[n]]; // RL6 RL3
        end
    end

    // Scan downward so the lowest active slot index is left standing.
    always_comb
    begin
        win_idx = '0;
        hit_any = 1'b0;
        for (int n = `VIC_NUM_SLOT - 1; n >= 0; n--)
        begin
            if (slot_hit[n])
            begin
                win_idx = vic_pkg::vic_slot_idx_t'(n); // RL7
                hit_any = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Core requests and vector
    // ----------------------------------------

    // Both core requests are registered so they never glitch.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            fast_reg <= 1'b0;
            irq_reg  <= 1'b0;
        end
        else
        begin
            fast_reg <= |fast_stat; // RL4 RL3
            irq_reg <= |irq_stat; // RL9 RL8
        end
    end

    // Vector follows the best slot, else the shared default routine.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            vect_reg <= `VIC_ZERO32;
        else if (hit_any)
            vect_reg <= slot_addr_reg[win_idx]; // RL10
        else
            vect_reg <= default_reg; // RL11 RL8
    end

    // ----------------------------------------
    // Summary interrupt
    // ----------------------------------------

    // Rising edges of the core requests are the events.
    assign events[`VIC_EV_FAST] = (|fast_stat) & ~fast_reg;
    assign events[`VIC_EV_IRQ] = (|irq_stat) & ~irq_reg;

    // A read clears the sticky bits, but an event in that cycle still lands.
    always_comb
    begin
        int_stat_next = int_stat_reg;
        if (rd_take && (a_off == `VIC_OFF_INT_STAT))
            int_stat_next = '0;
        int_stat_next = int_stat_next | events;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            int_stat_reg <= '0;
            int_reg      <= 1'b0;
        end
        else
        begin
            int_stat_reg <= int_stat_next;
            int_reg      <= |(int_stat_next & int_mask_reg);
        end
    end

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    assign a_off   = haddr_i[11:0];
    assign addr_ok = hsel_i && htrans_i[1] && hready_i;
    assign rd_take = addr_ok && !hwrite_i;

    // Read data is fetched in the address phase, giving zero wait states.
    always_comb
    begin
        rd_mux = `VIC_ZERO32;
        unique case (a_off)
            `VIC_OFF_FAST_STAT: rd_mux = 32'(fast_stat);   // RL5
            `VIC_OFF_IRQ_STAT: rd_mux = 32'(irq_stat);     // RL12
            `VIC_OFF_RAW:      rd_mux = 32'(req_reg);
            `VIC_OFF_ENABLE:   rd_mux = 32'(enable_reg);
            `VIC_OFF_SELECT:   rd_mux = 32'(select_reg);
            `VIC_OFF_VECT:     rd_mux = vect_reg;          // RL10 RL11
            `VIC_OFF_DEFAULT:  rd_mux = default_reg;
            `VIC_OFF_INT_STAT: rd_mux = 32'(int_stat_reg);
            `VIC_OFF_INT_MASK: rd_mux = 32'(int_mask_reg);
            default:
            begin
                if (a_off[7:6] == 2'h0 && a_off[11:8] == `VIC_PAGE_VADDR)
                    rd_mux = slot_addr_reg[a_off[5:2]];
                else if (a_off[7:6] == 2'h0 && a_off[11:8] == `VIC_PAGE_VCTRL)
                    rd_mux = 32'({slot_en_reg[a_off[5:2]], slot_src_reg[a_off[5:2]]});
                else
                    rd_mux = `VIC_ZERO32;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rdata_reg <= `VIC_ZERO32;
        else if (rd_take)
            rdata_reg <= rd_mux;
    end

    // Writes are held from the address phase to the data phase.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end
        else
        begin
            wr_pend_reg <= addr_ok && hwrite_i && (hsize_i == `VIC_HSIZE_WORD);
            if (addr_ok)
                wr_addr_reg <= a_off;
        end
    end

    // Class settings; a new value steers classification from the next cycle.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            enable_reg   <= '0;
            select_reg   <= '0;
            default_reg  <= `VIC_ZERO32;
            int_mask_reg <= '0;
        end
        else if (wr_pend_reg)
        begin
            if (wr_addr_reg == `VIC_OFF_ENABLE)
                enable_reg <= hwdata_i[`VIC_NUM_SRC-1:0];
            if (wr_addr_reg == `VIC_OFF_SELECT)
                select_reg <= hwdata_i[`VIC_NUM_SRC-1:0]; // RL2 RL1
            if (wr_addr_reg == `VIC_OFF_DEFAULT)
                default_reg <= hwdata_i; // RL11
            if (wr_addr_reg == `VIC_OFF_INT_MASK)
                int_mask_reg <= hwdata_i[`VIC_EV_W-1:0];
        end
    end

    // Slot table: routine address and source number with enable.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            slot_en_reg <= '0;
            for (int n = 0; n < `VIC_NUM_SLOT; n++)
            begin
                slot_addr_reg[n] <= `VIC_ZERO32;
                slot_src_reg[n]  <= '0; // RL14
            end
        end
        else if (wr_pend_reg && wr_addr_reg[7:6] == 2'h0)
        begin
            if (wr_addr_reg[11:8] == `VIC_PAGE_VADDR)
                slot_addr_reg[wr_addr_reg[5:2]] <= hwdata_i;
            if (wr_addr_reg[11:8] == `VIC_PAGE_VCTRL)
            begin
                slot_en_reg[wr_addr_reg[5:2]]  <= hwdata_i[`VIC_CTRL_EN]; // RL2 RL6
                slot_src_reg[wr_addr_reg[5:2]] <= hwdata_i[`VIC_SRC_W-1:0];
            end
        end
    end

    // Ready and response are constant flops so every output is registered.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
        else
        begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    assign hrdata_o                 = rdata_reg;
    assign fast_interrupt_request_o = fast_reg;
    assign irq_o                    = irq_reg;
    assign int_o                    = int_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    class_split_a: assert property ((fast_stat & irq_stat) == '0) // RL1
        else $error("A source is both fast and normal.");
    reclass_use_a: assert property (wr_pend_reg && wr_addr_reg == `VIC_OFF_SELECT // RL2
        |=> select_reg == $past(hwdata_i[`VIC_NUM_SRC-1:0]))
        else $error("Class write not applied.");
    fast_excl_a: assert property (|fast_stat && !(|irq_stat) |=> !irq_o) // RL3
        else $error("Fast source raised the normal request.");
    fast_merge_a: assert property (|(irq_req_i & enable_reg & select_reg) && !wr_pend_reg // RL4
        && $stable(enable_reg) && $stable(select_reg) |=> ##1 fast_interrupt_request_o)
        else $error("Fast request not merged.");
    fast_word_a: assert property (rd_take && a_off == `VIC_OFF_FAST_STAT // RL5
        |=> hrdata_o == 32'($past(req_reg & enable_reg & select_reg)))
        else $error("Fast status word wrong.");
    slot_top_a: assert property (slot_hit[0] |=> vect_reg == $past(slot_addr_reg[0])) // RL7
        else $error("Slot 0 did not win.");
    normal_merge_a: assert property (|irq_stat |=> irq_o) // RL9
        else $error("Normal request not merged.");
    vect_pick_a: assert property (hit_any |=> vect_reg == $past(slot_addr_reg[win_idx])) // RL10
        else $error("Vector is not the best slot.");
    vect_default_a: assert property (!hit_any |=> vect_reg == $past(default_reg)) // RL11
        else $error("Default vector not returned.");
    req_sample_a: assert property (irq_req_i[0] |=> req_reg[0]) // RL14
        else $error("Request not sampled.");

endmodule

// *** dv/vic_core_model.sv ***
// Purpose: Processor core side of the controller: takes the two request levels.
// Assumes: Requests are synchronous levels on clk_i.
// Notes:   Counts handler entries; a fast entry outranks a normal one in the same cycle.
`timescale 1ns/10ps
module vic_core_model
(
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // Request levels from the controller.
    input  wire logic fast_i,
    input  wire logic irq_i,
    // Handler entry counts.
    output int        fast_entries_o,
    output int        irq_entries_o
);
    logic fast_q;
    logic irq_q;

    // Enter a handler on each rising level; a normal rising level is dropped, not counted, while fast is up.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            fast_q         <= 1'b0;
            irq_q          <= 1'b0;
            fast_entries_o <= 0;
            irq_entries_o  <= 0;
        end
        else
        begin
            fast_q <= fast_i;
            irq_q  <= irq_i;
            if (fast_i && !fast_q)
                fast_entries_o <= fast_entries_o + 1;
            if (irq_i && !irq_q && !fast_i)
                irq_entries_o <= irq_entries_o + 1;
        end
    end
endmodule

// *** dv/test_vectored_interrupt_controller.sv ***
// Purpose: Self-checking bench of the controller against a behavioural model.
// Assumes: Zero-wait register slave; outputs follow requests two edges later.
// Notes:   Random requests and settings come from an LFSR seeded with 155.
`timescale 1ns/10ps
`include "vic_cfg.svh"
module test_vectored_interrupt_controller;
    logic clk_i = 1'b0, arst_n_i = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, lf = 32'h0000_009B;
    logic [1:0] htrans = 2'h0;
    logic hready, hresp, fast, irq, int_o;
    vic_pkg::vic_src_vec_t req = '0, en = '0, sel = '0;
    logic [31:0] s_adr [16], dflt;
    logic [5:0] s_ctl [16];
    // Registers read back after reset; the last offset is unmapped.
    logic [11:0] rst_off [8] = '{12'h00C, 12'h010, 12'h018, 12'h014,
                                 12'h020, 12'h100, 12'h200, 12'h024};
    int num_errors = 0, n_checks = 0, cyc = 0, fast_n, irq_n;

    always #20 clk_i = ~clk_i;

    vic_top dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(1'b1), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(`VIC_HSIZE_WORD), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .irq_req_i(req), .fast_interrupt_request_o(fast), .irq_o(irq), .int_o(int_o));
    vic_core_model core_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .fast_i(fast), .irq_i(irq),
        .fast_entries_o(fast_n), .irq_entries_o(irq_n));

    // ------------------------------------------------------------
    // Bus, compare and closing tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Address phase held until hready, then data phase held until hready again.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        haddr  <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_i); while (hready !== 1'b1);
        q = hrdata;
    endtask

    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Model of the vector: lowest enabled slot whose source is an active normal request.
    function automatic logic [31:0] exp_vect();
        for (int i = 0; i < 16; i++)
            if (s_ctl[i][5] && s_ctl[i][4:0] < 19 && req[s_ctl[i][4:0]] && en[s_ctl[i][4:0]]
                && !sel[s_ctl[i][4:0]])
                return s_adr[i];
        return dflt;
    endfunction

    // Hang guard; a full run needs well under ten thousand cycles.
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1'b1;
        foreach (s_ctl[i]) s_ctl[i] = 6'h00;
        dflt = 32'h0;
        // Settings clear on reset; an unmapped read answers zero.
        foreach (rst_off[i])
        begin
            xfer(1'b0, rst_off[i], 32'h0);
            chk("reset value", 32'h0, q);
            chk("bus response", 32'h0, {31'h0, hresp});
        end
        for (int k = 0; k < 24; k++)
        begin
            // Reassign classes and slots at run time every fourth round.
            if (k % 4 == 0)
            begin
                lf = nx(lf); en = lf[18:0]; lf = nx(lf); sel = lf[18:0]; lf = nx(lf);
                dflt = lf;
                xfer(1'b1, `VIC_OFF_ENABLE, {13'h0, en});
                xfer(1'b1, `VIC_OFF_SELECT, {13'h0, sel});
                xfer(1'b1, `VIC_OFF_DEFAULT, dflt);
                for (int n = 0; n < 16; n++)
                begin
                    lf = nx(lf); s_adr[n] = lf; s_ctl[n] = {lf[7], 5'((n * 3 + k) % 21)};
                    xfer(1'b1, {`VIC_PAGE_VADDR, 2'b00, 4'(n), 2'b00}, s_adr[n]);
                    xfer(1'b1, {`VIC_PAGE_VCTRL, 2'b00, 4'(n), 2'b00}, {26'h0, s_ctl[n]});
                end
            end
            lf = nx(lf);
            @(posedge clk_i);
            req <= lf[18:0] & {19{lf[k % 7 + 20]}};
            repeat (3) @(posedge clk_i);
            chk("fast out", {31'h0, |(req & en & sel)}, {31'h0, fast});
            chk("irq out", {31'h0, |(req & en & ~sel)}, {31'h0, irq});
            xfer(1'b0, `VIC_OFF_FAST_STAT, 32'h0);
            chk("fast status", {13'h0, req & en & sel}, q);
            xfer(1'b0, `VIC_OFF_IRQ_STAT, 32'h0);
            chk("normal status", {13'h0, req & en & ~sel}, q);
            xfer(1'b0, `VIC_OFF_VECT, 32'h0);
            chk("vector", exp_vect(), q);
        end
        // Sticky events, read clear and masking.
        xfer(1'b1, `VIC_OFF_ENABLE, 32'h0000_0003);
        xfer(1'b1, `VIC_OFF_SELECT, 32'h0000_0001);
        xfer(1'b1, `VIC_OFF_INT_MASK, 32'h0000_0001);
        @(posedge clk_i);
        req <= '0;
        repeat (4) @(posedge clk_i);
        xfer(1'b0, `VIC_OFF_INT_STAT, 32'h0);
        @(posedge clk_i);
        req <= 19'h00001;
        repeat (4) @(posedge clk_i);
        chk("event out", 32'h1, {31'h0, int_o});
        xfer(1'b0, `VIC_OFF_INT_STAT, 32'h0);
        chk("event status", 32'h1, q);
        repeat (3) @(posedge clk_i);
        chk("event cleared", 32'h0, {31'h0, int_o});
        req <= 19'h00003;
        repeat (4) @(posedge clk_i);
        chk("event masked", 32'h0, {31'h0, int_o});
        xfer(1'b0, `VIC_OFF_INT_STAT, 32'h0);
        chk("normal event", 32'h2, q);
        chk("core fast entry", 32'h1, {31'h0, fast_n != 0});
        report_and_stop();
    end
endmodule
